// ===== bench/tmr_cpu_model.sv
// cpu model: services timer interrupts by pulsing the ack inputs
// assumes irq levels synchronous to core_clk, delay set by the bench
module tmr_cpu_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic en,
  input wire logic [2:0] delay,
  input wire logic ovf_irq,
  input wire logic cmp_irq,
  output logic ovf_irq_ack,
  output logic cmp_irq_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  import tmr_pkg::*;
  logic [2:0] lat_r;
  always_ff @(posedge core_clk) begin
    ovf_irq_ack <= 1'h0;
    cmp_irq_ack <= 1'h0;
    if (!nrst || !en || !(ovf_irq || cmp_irq)) begin
      lat_r <= 3'h0;
    end else if (lat_r >= delay) begin
      cmp_irq_ack <= cmp_irq;
      ovf_irq_ack <= ovf_irq && !cmp_irq;
      lat_r <= 3'h0;
    end else begin
      lat_r <= lat_r + 3'h1;
    end
  end
endmodule : tmr_cpu_model

// ===== bench/tmr_top_asserts.sv
// checker for the timer top: bus handshakes, reset state, pin direction
// assumes one clock domain and a synchronous active-low reset
module tmr_top_asserts (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cmp_irq,
  input wire logic ovf_irq,
  input wire logic wave_pin_out,
  input wire logic wave_pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import tmr_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_reset_quiet: assert property (disable iff (1'h0) !nrst |=> !s_axi_bvalid && !s_axi_rvalid &&
    !ovf_irq && !cmp_irq && !wave_pin_out && wave_pin_oe_n) else $error("outputs active after reset");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("no write response");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read response");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_busy_refuse: assert property ((s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) and
    (s_axi_rvalid |-> !s_axi_arready)) else $error("request taken while busy");
  a_resp_code: assert property (s_axi_rvalid |-> s_axi_rresp == RESP_OKAY || s_axi_rresp == RESP_SLVERR)
    else $error("bad read response code");
  a_pin_dir_write: assert property ($past(nrst) && $changed(wave_pin_oe_n) |-> $rose(s_axi_bvalid))
    else $error("pin direction changed without write");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_cmp_irq: cover property ($rose(cmp_irq));
  c_pin_on: cover property (!wave_pin_oe_n && wave_pin_out);
endmodule : tmr_top_asserts
bind tmr_top tmr_top_asserts u_chk (.core_clk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_irq, .ovf_irq, .wave_pin_out, .wave_pin_oe_n);

// ===== bench/tmr_top_tb.sv
// bench for the timer: axi4-lite master, pin ticks, cpu model, checks
// assumes package, design, cpu model and checker compiled before it
module tmr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tmr_pkg::*;
  logic core_clk = 1'h0, nrst = 1'h0, ext_count_pin = 1'h0, cpu_en = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, cpu_dly = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d, v;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic ovf_irq_ack, cmp_irq_ack, ovf_irq, cmp_irq, wave_pin_out, wave_pin_oe_n;
  int bad_count = 0, tests_run = 0;
  always #2 core_clk = ~core_clk;
  tmr_top dut (.core_clk, .nrst, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_count_pin, .ovf_irq_ack, .cmp_irq_ack, .ovf_irq, .cmp_irq, .wave_pin_out, .wave_pin_oe_n);
  tmr_cpu_model u_cpu (.core_clk, .nrst, .en(cpu_en), .delay(cpu_dly), .ovf_irq, .cmp_irq, .ovf_irq_ack,
    .cmp_irq_ack);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  function automatic logic [31:0] ctl(input logic [2:0] cs, input logic [1:0] wm, input logic [1:0] om, input logic f);
    return (32'(cs) << CS_LSB) | (32'(wm) << WM_LSB) | (32'(om) << OM_LSB) | (32'(f) << FOC_BIT);
  endfunction : ctl
  function automatic int pre_div(input logic [2:0] cs);
    case (cs)
      CS_DIV1: return 1;
      CS_DIV8: return 8;
      CS_DIV64: return 64;
      CS_DIV256: return 256;
      default: return 1024;
    endcase
  endfunction : pre_div
  task automatic bus(input logic we, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, dn;
    logic [1:0] rs;
    int n;
    dn = 1'h0;
    n = 0;
    @(posedge core_clk);
    if (we) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
    end
    while (!dn && n < 99) begin
      @(negedge core_clk);
      ta = we ? s_axi_awready : s_axi_arready;
      tw = s_axi_wready;
      dn = we ? s_axi_bvalid : s_axi_rvalid;
      rs = we ? s_axi_bresp : s_axi_rresp;
      rd_d = s_axi_rdata;
      n++;
      @(posedge core_clk);
      if (ta && we) s_axi_awvalid <= 1'h0;
      if (ta && !we) s_axi_arvalid <= 1'h0;
      if (tw && we) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
    chk("answer", 32'h1, {31'h0, dn});
    chk("resp", {30'h0, er}, {30'h0, rs});
  endtask : bus
  task automatic w(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    bus(1'h1, a, d, RESP_OKAY);
  endtask : w
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string nm);
    bus(1'h0, a, 32'h0, RESP_OKAY);
    chk(nm, e, rd_d);
  endtask : rc
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge core_clk);
      ext_count_pin <= 1'h0;
      repeat (2) @(posedge core_clk);
      ext_count_pin <= 1'h1;
      repeat (3) @(posedge core_clk);
    end
  endtask : tk
  initial begin
    v = $urandom(75361);
    repeat (11) @(posedge core_clk);
    @(negedge core_clk);
    chk("pin", 32'h0, {31'h0, wave_pin_out});
    chk("oe_n", 32'h1, {31'h0, wave_pin_oe_n});
    @(posedge core_clk);
    nrst <= 1'h1;
    for (int i = 0; i < 6; i++) rc(8'(4 * i), 32'h0, "reset value");
    repeat (6) begin
      v = $urandom;
      w(OFS_COUNT, v);
      repeat (4) @(posedge core_clk);
      rc(OFS_COUNT, {24'h0, v[7:0]}, "count held");
    end
    w(OFS_COUNT, 32'hfe);
    w(OFS_CTRL, ctl(3'h7, WM_NORMAL, OM_NONE, 1'h0));
    tk(1);
    rc(OFS_COUNT, 32'hff, "count up");
    tk(1);
    rc(OFS_COUNT, 32'h0, "count wrap");
    rc(OFS_FLAG, 32'h1 << OVF_BIT, "overflow");
    w(OFS_FLAG, 32'h0);
    rc(OFS_FLAG, 32'h1 << OVF_BIT, "zero write");
    w(OFS_FLAG, 32'h1 << OVF_BIT);
    rc(OFS_FLAG, 32'h0, "one write");
    w(OFS_COMPARE, 32'h5);
    w(OFS_COUNT, 32'h5);
    tk(1);
    rc(OFS_FLAG, 32'h0, "blocked match");
    w(OFS_COUNT, 32'h3);
    tk(2);
    rc(OFS_FLAG, 32'h0, "early match");
    tk(1);
    rc(OFS_FLAG, 32'h1 << CMP_BIT, "match flag");
    w(OFS_PORT, 32'h1 << GIE_BIT);
    chk("masked irq", 32'h0, {31'h0, cmp_irq});
    w(OFS_MASK, 32'h1 << CMP_BIT);
    chk("cmp irq", 32'h1, {31'h0, cmp_irq});
    w(OFS_PORT, 32'h0);
    chk("no global", 32'h0, {31'h0, cmp_irq});
    cpu_dly <= 3'h5;
    cpu_en <= 1'h1;
    w(OFS_PORT, 32'h1 << GIE_BIT);
    for (int i = 0; i < 60 && cmp_irq === 1'h1; i++) @(posedge core_clk);
    rc(OFS_FLAG, 32'h0, "serviced");
    for (int m = 0; m < 4; m++) begin
      w(OFS_CTRL, ctl(3'h0, 2'(m), OM_NONE, 1'h0));
      rc(OFS_CTRL, ctl(3'h0, 2'(m), OM_NONE, 1'h0), "mode");
    end
    w(OFS_CTRL, ctl(3'h7, WM_CTC, OM_NONE, 1'h0));
    w(OFS_COMPARE, 32'h2);
    w(OFS_COUNT, 32'h0);
    tk(3);
    rc(OFS_COUNT, 32'h0, "ctc clear");
    w(OFS_PORT, 32'h0);
    w(OFS_FLAG, 32'h3);
    w(OFS_CTRL, ctl(3'h0, WM_NORMAL, OM_TOGGLE, 1'h1));
    rc(OFS_PORT, 32'h20, "forced wave");
    rc(OFS_FLAG, 32'h0, "force flag");
    w(OFS_PORT, 32'h1 << PORT_DIR_BIT);
    @(negedge core_clk);
    chk("oe_n", 32'h0, {31'h0, wave_pin_oe_n});
    chk("pin wave", 32'h1, {31'h0, wave_pin_out});
    w(OFS_CTRL, ctl(3'h0, WM_NORMAL, OM_NONE, 1'h1));
    @(negedge core_clk);
    chk("pin port", 32'h0, {31'h0, wave_pin_out});
    rc(OFS_PORT, 32'h22, "om zero");
    w(OFS_CTRL, ctl(3'h0, WM_FAST_PWM, OM_TOGGLE, 1'h0));
    rc(OFS_PORT, 32'h22, "mode change");
    w(OFS_CTRL, ctl(3'h0, WM_FAST_PWM, OM_TOGGLE, 1'h1));
    rc(OFS_PORT, 32'h22, "pwm force");
    w(OFS_CTRL, ctl(3'h0, WM_NORMAL, OM_NONE, 1'h0));
    w(OFS_COMPARE, 32'h2);
    w(OFS_CTRL, ctl(3'h7, WM_FAST_PWM, OM_NONE, 1'h0));
    w(OFS_COMPARE, 32'h9);
    w(OFS_COUNT, 32'h0);
    w(OFS_FLAG, 32'h3);
    tk(3);
    rc(OFS_FLAG, 32'h1 << CMP_BIT, "active compare");
    rc(OFS_COMPARE, 32'h9, "buffer");
    cpu_en <= 1'h0;
    // a window of win edges holds exactly win / divisor prescaler ticks
    for (int s = 1; s < 6; s++) begin
      int win;
      win = (s == 1) ? 8 : 2 * pre_div(3'(s));
      w(OFS_COUNT, 32'h0);
      w(OFS_CTRL, ctl(3'(s), WM_NORMAL, OM_NONE, 1'h0));
      repeat (win - 3) @(posedge core_clk);
      w(OFS_CTRL, ctl(CS_STOP, WM_NORMAL, OM_NONE, 1'h0));
      rc(OFS_COUNT, 32'(win / pre_div(3'(s))), "prescaled count");
    end
    w(OFS_COUNT, 32'h0);
    w(OFS_CTRL, ctl(CS_EXT_FALL, WM_NORMAL, OM_NONE, 1'h0));
    tk(2);
    rc(OFS_COUNT, 32'h2, "falling edge");
    w(OFS_FLAG, 32'h3);
    w(OFS_CTRL, ctl(CS_EXT_RISE, WM_PC_PWM, OM_NONE, 1'h0));
    w(OFS_COUNT, 32'hfe);
    tk(3);
    rc(OFS_COUNT, 32'hfd, "turn at max");
    w(OFS_COUNT, 32'h1);
    tk(2);
    rc(OFS_COUNT, 32'h1, "turn at bottom");
    rc(OFS_FLAG, 32'h1 << OVF_BIT, "bottom overflow");
    w(OFS_MASK, 32'h1 << OVF_BIT);
    w(OFS_PORT, 32'h1 << GIE_BIT);
    chk("ovf irq", 32'h1, {31'h0, ovf_irq});
    s_axi_wstrb <= 4'he;
    w(OFS_MASK, 32'h3);
    s_axi_wstrb <= 4'hf;
    rc(OFS_MASK, 32'h1 << OVF_BIT, "strobe off");
    bus(1'h1, 8'h20, 32'h0, RESP_SLVERR);
    bus(1'h0, 8'h20, 32'h0, RESP_SLVERR);
    close_out();
  end
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
endmodule : tmr_top_tb

// ===== common/tmr_pkg.sv
// package for the 8-bit single compare timer: register map, fields, modes
// assumes an axi4-lite master with 32-bit data and one clock domain
package tmr_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COMPARE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FLAG = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PORT = 8'h14;
  // control register fields
  localparam int CS_LSB = 0;
  localparam int WM_LSB = 3;
  localparam int OM_LSB = 5;
  localparam int FOC_BIT = 7;
  // flag and mask fields
  localparam int OVF_BIT = 0;
  localparam int CMP_BIT = 1;
  // port register fields
  localparam int PORT_VAL_BIT = 0;
  localparam int PORT_DIR_BIT = 1;
  localparam int GIE_BIT = 2;
  localparam int ACK_OVF_BIT = 3;
  localparam int ACK_CMP_BIT = 4;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [9:0] PRE_MASK8 = 10'h007;
  localparam logic [9:0] PRE_MASK64 = 10'h03f;
  localparam logic [9:0] PRE_MASK256 = 10'h0ff;
  localparam logic [9:0] PRE_MASK1024 = 10'h3ff;
  localparam logic [1:0] WM_NORMAL = 2'h0;
  localparam logic [1:0] WM_PC_PWM = 2'h1;
  localparam logic [1:0] WM_CTC = 2'h2;
  localparam logic [1:0] WM_FAST_PWM = 2'h3;
  localparam logic [1:0] OM_NONE = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR = 2'h2;
  localparam logic [1:0] OM_SET = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {TMR_UP, TMR_DOWN} tmr_dir_t;
endpackage : tmr_pkg

// ===== design/tmr_top.sv
// 8-bit timer/counter with one compare channel behind an axi4-lite slave
// assumes one clock, synchronous active-low reset, inputs synchronous to core_clk
//
// Local design decisions: register access over AXI4-Lite and the address map.
module tmr_top (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [tmr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tmr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_count_pin,
  input wire logic ovf_irq_ack,
  input wire logic cmp_irq_ack,
  output logic ovf_irq,
  output logic cmp_irq,
  output logic wave_pin_out,
  output logic wave_pin_oe_n
);
  import tmr_pkg::*;

  logic [7:0] count_value_r, count_value_nxt;
  logic [7:0] compare_value_r, compare_value_nxt;
  logic [7:0] compare_buf_r, compare_buf_nxt;
  logic [2:0] clock_select_r;
  logic [1:0] wave_mode_r;
  logic [1:0] output_mode_r;
  logic [1:0] irq_flag_r, irq_flag_nxt;
  logic [1:0] irq_mask_r;
  logic port_val_r, wave_pin_direction_r, gie_r;
  logic wave_out_r, wave_out_nxt;
  tmr_dir_t dir_r, dir_nxt;
  logic [9:0] pre_r;
  logic ext_q_r;
  logic block_r, block_nxt;
  logic aw_held_r, w_held_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;

  // register write path: address and data may arrive in either order
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  wire aw_have = aw_held_r || aw_take;
  wire w_have = w_held_r || w_take;
  wire wr_go = aw_have && w_have && !s_axi_bvalid;
  wire [ADDR_W-1:0] wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
  wire [31:0] wr_data = w_held_r ? w_data_r : s_axi_wdata;
  wire [3:0] wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
  wire wr_b0 = wr_go && wr_strb[0];
  wire [7:0] wd = wr_data[7:0];
  wire wr_ctrl = wr_b0 && (wr_addr == OFS_CTRL);
  wire wr_count = wr_b0 && (wr_addr == OFS_COUNT);
  wire wr_compare = wr_b0 && (wr_addr == OFS_COMPARE);
  wire wr_flag = wr_b0 && (wr_addr == OFS_FLAG);
  wire wr_mask = wr_b0 && (wr_addr == OFS_MASK);
  wire wr_port = wr_b0 && (wr_addr == OFS_PORT);
  wire wr_known = (wr_addr == OFS_CTRL) || (wr_addr == OFS_COUNT) || (wr_addr == OFS_COMPARE) ||
                  (wr_addr == OFS_FLAG) || (wr_addr == OFS_MASK) || (wr_addr == OFS_PORT);

  // tick generation: prescaler or external pin edge
  wire ext_rise = ext_count_pin && !ext_q_r;
  wire ext_fall = !ext_count_pin && ext_q_r;
  logic timer_tick;
  always_comb begin
    case (clock_select_r)
      CS_STOP: timer_tick = 1'b0;
      CS_DIV1: timer_tick = 1'b1;
      CS_DIV8: timer_tick = (pre_r & PRE_MASK8) == PRE_MASK8;
      CS_DIV64: timer_tick = (pre_r & PRE_MASK64) == PRE_MASK64;
      CS_DIV256: timer_tick = (pre_r & PRE_MASK256) == PRE_MASK256;
      CS_EXT_FALL: timer_tick = ext_fall;
      CS_EXT_RISE: timer_tick = ext_rise;
      CS_DIV1024: timer_tick = (pre_r & PRE_MASK1024) == PRE_MASK1024;
      default: timer_tick = 1'b0;
    endcase
  end

  // counter decode
  wire pwm_mode = (wave_mode_r == WM_PC_PWM) || (wave_mode_r == WM_FAST_PWM);
  wire at_bottom = count_value_r == CNT_BOTTOM;
  wire at_max = count_value_r == CNT_MAX;
  wire match_raw = count_value_r == compare_value_r;
  wire match = match_raw && !block_r;
  wire do_match = timer_tick && match;
  wire fast_bottom = timer_tick && (wave_mode_r == WM_FAST_PWM) && at_max && output_mode_r[1];
  // force is ignored while a pwm mode runs; its action comes from the same write
  wire ctrl_force = wr_ctrl && wd[FOC_BIT] && !pwm_mode;

  function automatic logic wave_action(input logic [1:0] mode, input logic cur);
    case (mode)
      OM_TOGGLE: wave_action = !cur;
      OM_CLEAR: wave_action = 1'b0;
      OM_SET: wave_action = 1'b1;
      default: wave_action = cur;
    endcase
  endfunction : wave_action

  // counter, direction, overflow and double buffer update
  logic ovf_set;
  logic reload;
  always_comb begin
    count_value_nxt = count_value_r;
    dir_nxt = dir_r;
    ovf_set = 1'b0;
    reload = 1'b0;
    if (timer_tick) begin
      case (wave_mode_r)
        WM_NORMAL: begin
          count_value_nxt = count_value_r + 8'h01;
          ovf_set = at_max;
        end
        WM_CTC: begin
          // a blocked match must not clear the count either
          count_value_nxt = match ? CNT_BOTTOM : count_value_r + 8'h01;
          ovf_set = at_max;
        end
        WM_FAST_PWM: begin
          count_value_nxt = at_max ? CNT_BOTTOM : count_value_r + 8'h01;
          ovf_set = at_max;
          reload = at_max;
        end
        WM_PC_PWM: begin
          if (dir_r == TMR_UP) begin
            count_value_nxt = at_max ? count_value_r - 8'h01 : count_value_r + 8'h01;
            dir_nxt = at_max ? TMR_DOWN : TMR_UP;
            reload = at_max;
          end else begin
            count_value_nxt = at_bottom ? count_value_r + 8'h01 : count_value_r - 8'h01;
            dir_nxt = at_bottom ? TMR_UP : TMR_DOWN;
            ovf_set = at_bottom;
          end
        end
        default: count_value_nxt = count_value_r;
      endcase
    end
    if (wr_count) begin
      count_value_nxt = wd;
    end
  end

  // compare register and buffer
  always_comb begin
    compare_value_nxt = compare_value_r;
    compare_buf_nxt = compare_buf_r;
    if (wr_compare) begin
      if (pwm_mode) begin
        compare_buf_nxt = wd;
      end else begin
        compare_value_nxt = wd;
        compare_buf_nxt = wd;
      end
    end
    if (pwm_mode && reload) begin
      compare_value_nxt = compare_buf_r;
    end
  end

  // wave output: matches, fast pwm bottom action and force
  logic [1:0] pwm_match_mode;
  always_comb begin
    wave_out_nxt = wave_out_r;
    pwm_match_mode = output_mode_r;
    if (wave_mode_r == WM_PC_PWM && dir_r == TMR_DOWN && output_mode_r[1]) begin
      pwm_match_mode = output_mode_r ^ 2'h1;
    end
    if (do_match) begin
      wave_out_nxt = wave_action(pwm_match_mode, wave_out_r);
    end else if (fast_bottom) begin
      wave_out_nxt = !output_mode_r[0];
    end
    if (ctrl_force) begin
      wave_out_nxt = wave_action(wd[OM_LSB +: 2], wave_out_r);
    end
  end

  // flags: hardware set wins over clear
  always_comb begin
    irq_flag_nxt = irq_flag_r;
    if (wr_flag) begin
      irq_flag_nxt = irq_flag_r & ~wd[1:0];
    end
    if (ovf_irq_ack) begin
      irq_flag_nxt[OVF_BIT] = 1'b0;
    end
    if (cmp_irq_ack) begin
      irq_flag_nxt[CMP_BIT] = 1'b0;
    end
    if (ovf_set) begin
      irq_flag_nxt[OVF_BIT] = 1'b1;
    end
    if (do_match) begin
      irq_flag_nxt[CMP_BIT] = 1'b1;
    end
  end

  // a count write blocks matches until the next tick has passed
  always_comb begin
    block_nxt = block_r;
    if (timer_tick) begin
      block_nxt = 1'b0;
    end
    if (wr_count) begin
      block_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      count_value_r <= CNT_BOTTOM;
      compare_value_r <= CNT_BOTTOM;
      compare_buf_r <= CNT_BOTTOM;
      dir_r <= TMR_UP;
      irq_flag_r <= 2'h0;
      wave_out_r <= 1'b0;
      block_r <= 1'b0;
      pre_r <= 10'h000;
      ext_q_r <= 1'b0;
    end else begin
      count_value_r <= count_value_nxt;
      compare_value_r <= compare_value_nxt;
      compare_buf_r <= compare_buf_nxt;
      dir_r <= dir_nxt;
      irq_flag_r <= irq_flag_nxt;
      wave_out_r <= wave_out_nxt;
      block_r <= block_nxt;
      pre_r <= pre_r + 10'h001;
      ext_q_r <= ext_count_pin;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      clock_select_r <= CS_STOP;
      wave_mode_r <= WM_NORMAL;
      output_mode_r <= OM_NONE;
      irq_mask_r <= 2'h0;
      port_val_r <= 1'b0;
      wave_pin_direction_r <= 1'b0;
      gie_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        clock_select_r <= wd[CS_LSB +: 3];
        wave_mode_r <= wd[WM_LSB +: 2];
        output_mode_r <= wd[OM_LSB +: 2];
      end
      if (wr_mask) begin
        irq_mask_r <= wd[1:0];
      end
      if (wr_port) begin
        port_val_r <= wd[PORT_VAL_BIT];
        wave_pin_direction_r <= wd[PORT_DIR_BIT];
        gie_r <= wd[GIE_BIT];
      end
    end
  end

  // interrupts and pin
  assign ovf_irq = irq_flag_r[OVF_BIT] && irq_mask_r[OVF_BIT] && gie_r;
  assign cmp_irq = irq_flag_r[CMP_BIT] && irq_mask_r[CMP_BIT] && gie_r;
  assign wave_pin_out = (output_mode_r != OM_NONE) ? wave_out_r : port_val_r;
  assign wave_pin_oe_n = !wave_pin_direction_r;

  // write channel holding and response
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_held_r <= 1'b1;
          aw_addr_r <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held_r <= 1'b1;
          w_data_r <= s_axi_wdata;
          w_strb_r <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // read channel
  assign s_axi_arready = !s_axi_rvalid;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  logic [31:0] rd_val;
  logic rd_ok;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      OFS_CTRL: rd_val[7:0] = {1'b0, output_mode_r, wave_mode_r, clock_select_r};
      OFS_COUNT: rd_val[7:0] = count_value_r;
      OFS_COMPARE: rd_val[7:0] = pwm_mode ? compare_buf_r : compare_value_r;
      OFS_FLAG: rd_val[1:0] = irq_flag_r;
      OFS_MASK: rd_val[1:0] = irq_mask_r;
      OFS_PORT: rd_val[5:0] = {wave_out_r, 2'h0, gie_r, wave_pin_direction_r, port_val_r};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : tmr_top
